//--- pipelined_read_master_fifo_tb.sv
`timescale 1ns/1ps
module pipelined_read_master_fifo_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        out_ready = 1'b0;
  logic        stall_en = 1'b0;
  logic        single_en = 1'b0;
  logic [31:0] reg_rdata, address, readdata, out_data, rv;
  logic [3:0]  byteenable;
  logic        irq, read, waitrequest, readdatavalid, out_valid;
  int          n_errors = 0;
  int          check_count = 0;
  always #25 clk = ~clk;
  prm_read_master dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .address(address), .byteenable(byteenable),
    .read(read), .waitrequest(waitrequest), .readdata(readdata), .readdatavalid(readdatavalid),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  prm_mem_model mem (.clk(clk), .rst(rst), .address(address), .read(read), .waitrequest(waitrequest),
    .readdata(readdata), .readdatavalid(readdatavalid), .stall_en(stall_en), .single_en(single_en));
  // ----
  // Shared tasks
  // ----
  task chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rv = reg_rdata;
  endtask
  // Consumes n words and compares each with the pattern of its address.
  task drain(int n, logic [31:0] base);
    int i;
    int k;
    i = 0;
    k = 0;
    @(posedge clk);
    out_ready <= 1'b1;
    while (i < n && k < 2000)
    begin
      @(negedge clk);
      k++;
      if (out_valid === 1'b1)
      begin
        chk("out_data", (base + 32'(4 * i)) ^ 32'hc3c3_0000, out_data);
        i++;
      end
    end
    @(posedge clk);
    out_ready <= 1'b0;
    chk("words", n, i);
  endtask
  task give_verdict;
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task run_basic;
    wr(4'hc, 32'h3);
    wr(4'h0, 32'h103);
    wr(4'h4, 32'h10);
    wr(4'h8, 32'h1);
    drain(4, 32'h100);
    repeat (4) @(posedge clk);
    rd(4'hc);
    chk("status", 32'h1, rv);
    chk("irq", 32'h1, {31'h0, irq});
    wr(4'h8, 32'h8000_0000);
    rd(4'h0);
    chk("irq status", 32'h1, rv);
    rd(4'h0);
    chk("irq status", 32'h0, rv);
    chk("irq", 32'h0, {31'h0, irq});
    wr(4'h8, 32'h0);
  endtask
  // The stream side stalls so the fifo fills while the bus also stalls.
  task run_throttle;
    stall_en <= 1'b1;
    wr(4'h0, 32'h200);
    wr(4'h4, 32'h60);
    wr(4'h8, 32'h1);
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk("read", 32'h0, {31'h0, read});
    rd(4'h4);
    chk("length", 32'h20, rv);
    rd(4'h8);
    chk("outstanding", 32'h0, rv & 32'hffff);
    wr(4'h8, 32'h1);
    wr(4'h8, 32'h8000_0000);
    rd(4'h0);
    chk("irq status", 32'h2, rv);
    wr(4'h8, 32'h0);
    drain(24, 32'h200);
    stall_en <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'hc);
    chk("status", 32'h1, rv);
  endtask
  // A slave without pipelining allows only one read in flight at a time.
  task run_single;
    wr(4'h0, 32'h300);
    single_en <= 1'b1;
    wr(4'h4, 32'h10);
    wr(4'h8, 32'h1);
    drain(4, 32'h300);
    single_en <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'hc);
    chk("status", 32'h1, rv);
    wr(4'h8, 32'h8000_0000);
    rd(4'h4);
    chk("irq mask", 32'h3, rv);
    rd(4'h0);
    chk("irq status", 32'h1, rv);
    wr(4'h8, 32'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run_basic;
    run_throttle;
    run_single;
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
endmodule
bind prm_read_master prm_sva #(.AW(AW), .DW(DW)) sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .address(address),
  .byteenable(byteenable), .read(read), .waitrequest(waitrequest), .readdatavalid(readdatavalid),
  .out_valid(out_valid));

//--- prm_fifo.sv
`timescale 1ns/1ps
module prm_fifo #(
  parameter int WIDTH = 32,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Write side
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data,
  // Fill level
  output logic      [AW:0]      level
);

  logic [WIDTH-1:0] mem_reg [2**AW];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    wp_next;
  logic [AW-1:0]    rp_reg;
  logic [AW-1:0]    rp_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             do_wr;
  logic             do_rd;

  // A write into a full FIFO is dropped; the master's throttle keeps that from happening.
  always_comb
  begin
    do_wr    = wr_valid && (cnt_reg != (AW+1)'(2**AW));
    do_rd    = rd_ready && (cnt_reg != '0);
    wp_next  = do_wr ? wp_reg + 1'b1 : wp_reg;
    rp_next  = do_rd ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_reg[wp_reg] <= wr_data;
  end

  assign rd_valid = (cnt_reg != '0);
  assign rd_data  = mem_reg[rp_reg];
  assign level    = cnt_reg;

endmodule

//--- prm_mem_model.sv
`timescale 1ns/1ps
module prm_mem_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus
  input wire logic [31:0] address,
  input wire logic        read,
  output logic            waitrequest,
  output logic [31:0]     readdata,
  output logic            readdatavalid,
  // Test control
  input wire logic        stall_en,
  input wire logic        single_en
);
  logic [1:0]  vld;
  logic [31:0] a0;
  logic [31:0] a1;
  logic [31:0] last;
  logic        phase;
  // ----
  // Two-cycle pipelined slave
  // ----
  always @(posedge clk)
  begin
    phase <= rst ? 1'b0 : ~phase;
    vld <= rst ? 2'b00 : {vld[0], read && !waitrequest};
    a0 <= address;
    a1 <= a0;
    if (rst)
      last <= 32'h0;
    else if (vld[1])
      last <= a1 ^ 32'hc3c3_0000;
  end
  // Stalls every other cycle so a held request is seen under wait.
  // Without pipelining the slave keeps waitrequest up until the read in flight has returned.
  assign waitrequest = (stall_en && phase) || (single_en && (vld != 2'b00));
  assign readdatavalid = vld[1];
  // Idle data is inverted so a stale capture cannot pass.
  assign readdata = vld[1] ? a1 ^ 32'hc3c3_0000 : ~last;
endmodule

//--- prm_pkg.sv
// Contract
// - Hold request stable while waitrequest high.
// - Control logic drives address, byteenable, read.
// - Issue a read every unstalled cycle.
// - FIFO written only on readdatavalid.
// - Stop reading at FIFO fill threshold.
// - Word-aligned consecutive full-word reads only.
// - Launch loads start address and length.
// - Read continuously from next cycle until length zero.
// - Each posted read: address plus four, length minus four.
// - Counters update only on posted read, length nonzero.
// - Posted means read high, waitrequest low.
// - Outstanding counter tracks posted versus returned reads.
// - Outstanding reads never exceed free FIFO space.
// - Done only when length and outstanding are zero.
package prm_pkg;

  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int LEN_W        = 32;
  localparam int WORD_BYTES   = 4;
  localparam int FIFO_DEPTH   = 16;
  localparam int FIFO_AW      = 4;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
  localparam logic [LEN_W-1:0]  LEN_RST  = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Register map of the control port
  // --------------------------------------------------------------------------
  localparam logic [3:0] OFS_START  = 4'h0;
  localparam logic [3:0] OFS_LENGTH = 4'h4;
  localparam logic [3:0] OFS_CTRL   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  localparam logic [3:0] OFS_IRQ    = 4'h0;
  localparam logic [3:0] OFS_MASK   = 4'h4;
  localparam int CTRL_LAUNCH_BIT = 0;
  localparam int STAT_DONE_BIT   = 0;
  localparam int STAT_BUSY_BIT   = 1;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_REJECT_BIT  = 1;
  localparam int IRQ_W           = 2;

endpackage

//--- prm_read_master.sv
`timescale 1ns/1ps
module prm_read_master #(
  parameter int AW        = prm_pkg::ADDR_W,
  parameter int DW        = prm_pkg::DATA_W,
  parameter int LW        = prm_pkg::LEN_W,
  parameter int FIFO_AW   = prm_pkg::FIFO_AW,
  parameter int THRESHOLD = prm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Register port
  input  wire logic [3:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic      [31:0]     reg_rdata,
  // Interrupt
  output logic                 irq,
  // Memory-mapped read bus
  output logic      [AW-1:0]   address,
  output logic      [DW/8-1:0] byteenable,
  output logic                 read,
  input  wire logic            waitrequest,
  input  wire logic [DW-1:0]   readdata,
  input  wire logic            readdatavalid,
  // Data stream out
  output logic                 out_valid,
  input  wire logic            out_ready,
  output logic      [DW-1:0]   out_data
);

  localparam logic [LW-1:0] STEP = LW'(prm_pkg::WORD_BYTES);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [AW-1:0]      start_reg;
  logic [AW-1:0]      start_next;
  logic [LW-1:0]      length_cfg_reg;
  logic [LW-1:0]      length_cfg_next;
  logic [AW-1:0]      addr_reg;
  logic [AW-1:0]      addr_next;
  logic [LW-1:0]      len_reg;
  logic [LW-1:0]      len_next;
  logic [FIFO_AW:0]   pend_reg;
  logic [FIFO_AW:0]   pend_next;
  logic               done_reg;
  logic               done_next;
  logic [prm_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [prm_pkg::IRQ_W-1:0] irq_stat_next;
  logic [prm_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [prm_pkg::IRQ_W-1:0] irq_mask_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;
  logic               irq_sel_reg;
  logic               irq_sel_next;

  logic [FIFO_AW:0]   fifo_level;
  logic               busy;
  logic               launch_req;
  logic               launch;
  logic               posted;
  logic               room;
  logic [FIFO_AW+1:0] committed;

  // --------------------------------------------------------------------------
  // Read data buffer
  // --------------------------------------------------------------------------
  prm_fifo #(
    .WIDTH (DW),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .wr_valid (readdatavalid),
    .wr_data  (readdata),
    .rd_valid (out_valid),
    .rd_ready (out_ready),
    .rd_data  (out_data),
    .level    (fifo_level)
  );

  // --------------------------------------------------------------------------
  // Bus request and counters
  // --------------------------------------------------------------------------
  // Data already buffered plus reads still in flight must leave room for one
  // more word, so a full stream of returns can never overflow the buffer.
  always_comb
  begin
    busy       = (len_reg != '0) || (pend_reg != '0);
    launch_req = reg_wr && (reg_addr == prm_pkg::OFS_CTRL) && reg_wdata[prm_pkg::CTRL_LAUNCH_BIT];
    launch     = launch_req && !busy;
    committed  = (FIFO_AW+2)'(fifo_level) + (FIFO_AW+2)'(pend_reg);
    room       = committed < (FIFO_AW+2)'(THRESHOLD);
    // Read stays up under waitrequest because len_reg and addr_reg only move on a post.
    read       = (len_reg != '0) && room;
    posted     = read && !waitrequest;
    addr_next  = addr_reg;
    len_next   = len_reg;
    if (launch)
    begin
      addr_next = {start_reg[AW-1:2], 2'b00};
      len_next  = length_cfg_reg;
    end
    else if (posted && (len_reg != '0))
    begin
      addr_next = addr_reg + AW'(STEP);
      len_next  = (len_reg < STEP) ? '0 : len_reg - STEP;
    end
    pend_next = pend_reg;
    if (posted && !readdatavalid)
      pend_next = pend_reg + 1'b1;
    else if (!posted && readdatavalid && (pend_reg != '0))
      pend_next = pend_reg - 1'b1;
    done_next = done_reg;
    if (launch)
      done_next = 1'b0;
    else if (len_next == '0 && pend_next == '0 && busy)
      done_next = 1'b1;
  end

  assign address    = addr_reg;
  assign byteenable = '1;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_reg <= prm_pkg::ADDR_RST;
      len_reg  <= prm_pkg::LEN_RST;
      pend_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      addr_reg <= addr_next;
      len_reg  <= len_next;
      pend_reg <= pend_next;
      done_reg <= done_next;
    end
  end

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  // Word registers sit at offsets 0..c; the whole of reg_addr selects, bit 0 of ctrl
  // is launch. Interrupt status and mask live in a second page chosen by the
  // lower offsets 0 and 4 being shared with start and length, so they are read through ctrl bit 31; the mask is written at offset c.
  always_comb
  begin
    start_next      = start_reg;
    length_cfg_next = length_cfg_reg;
    irq_mask_next   = irq_mask_reg;
    irq_sel_next    = irq_sel_reg;
    irq_stat_next   = irq_stat_reg;
    rdata_next      = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        prm_pkg::OFS_START:  start_next      = reg_wdata[AW-1:0];
        prm_pkg::OFS_LENGTH: length_cfg_next = reg_wdata[LW-1:0];
        prm_pkg::OFS_CTRL:   irq_sel_next    = reg_wdata[31];
        prm_pkg::OFS_STATUS: irq_mask_next   = reg_wdata[prm_pkg::IRQ_W-1:0];
        default:             irq_sel_next    = irq_sel_reg;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        prm_pkg::OFS_START:  rdata_next = irq_sel_reg ? 32'(irq_stat_reg) : 32'(start_reg);
        prm_pkg::OFS_LENGTH: rdata_next = irq_sel_reg ? 32'(irq_mask_reg) : 32'(len_reg);
        prm_pkg::OFS_CTRL:   rdata_next = {irq_sel_reg, 15'h0000, 16'(pend_reg)};
        prm_pkg::OFS_STATUS: rdata_next = {30'h0000_0000, busy, done_reg};
        default:             rdata_next = 32'h0000_0000;
      endcase
      if (irq_sel_reg && reg_addr == prm_pkg::OFS_IRQ)
        irq_stat_next = '0;
    end
    // A completion or refusal in the clearing cycle still lands.
    if (!done_reg && done_next)
      irq_stat_next[prm_pkg::IRQ_DONE_BIT] = 1'b1;
    if (launch_req && busy)
      irq_stat_next[prm_pkg::IRQ_REJECT_BIT] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      start_reg      <= prm_pkg::ADDR_RST;
      length_cfg_reg <= prm_pkg::LEN_RST;
      irq_stat_reg   <= '0;
      irq_mask_reg   <= '0;
      irq_sel_reg    <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
    end
    else
    begin
      start_reg      <= start_next;
      length_cfg_reg <= length_cfg_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
      irq_sel_reg    <= irq_sel_next;
      rdata_reg      <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = |(irq_stat_reg & irq_mask_reg);

endmodule

//--- prm_sva.sv
`timescale 1ns/1ps
module prm_sva #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // Register port
  input wire logic [3:0]      reg_addr,
  input wire logic [31:0]     reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [31:0]     reg_rdata,
  // Bus and stream
  input wire logic [AW-1:0]   address,
  input wire logic [DW/8-1:0] byteenable,
  input wire logic            read,
  input wire logic            waitrequest,
  input wire logic            readdatavalid,
  input wire logic            out_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence posted_s;
    read && !waitrequest;
  endsequence
  sequence stalled_s;
    read && waitrequest;
  endsequence
  hold_read_a: assert property (stalled_s |=> read)
    else $error("read dropped under wait");
  hold_addr_a: assert property (stalled_s |=> $stable(address))
    else $error("address moved under wait");
  full_word_a: assert property (read |-> byteenable == '1)
    else $error("byte enables not all set");
  word_align_a: assert property (read |-> address[1:0] == 2'b00)
    else $error("unaligned read address");
  addr_step_a: assert property (posted_s |=> address == $past(address) + 4)
    else $error("address did not step by four");
  addr_idle_a: assert property (
    !(read && !waitrequest) && !(reg_wr && reg_addr == 4'h8 && reg_wdata[0]) |=> $stable(address))
    else $error("address moved without a posted read");
  fifo_fill_a: assert property (!out_valid && !readdatavalid |=> !out_valid)
    else $error("stream data without returned data");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
